// [core/sesg_top.sv]
// Status event summary group: condition, transition filters,
// latched events, enable mask, summary word and a status queue.
// Assumes all inputs come from logic on mclk; commands are pulses.
//
// Summary of operation
// RQ1: Filtered condition transition sets its event bit.
// RQ2: Event bits stay set until queried or cleared by clear-status.
// RQ3: Repeated events on a set bit change nothing; no count kept.
// RQ4: Event register read-only, 16 bits, unused bits read zero.
// RQ5: Positions without filter pair set directly from internal event.
// RQ6: Summary is OR of event AND enable across all bits.
// RQ7: Enable read-write; unused bits read zero, writes to them dropped.
// RQ8: Enable kept across clear-status and queries.
// RQ9: Summaries appear only as bits of a higher-level word.
// RQ10: Status queue returns entries in arrival order.
// RQ11: Queue summary is 1 while queue holds an entry, else 0.
// RQ12: Reading all entries empties the queue.
// RQ13: Clear-status empties status queues, never the output queue.
// RQ14: Host should pause about .1 second between polls.
// RQ15: Rise sets on 0-to-1 with rise bit; fall on 1-to-0 with fall bit.
// RQ16: Power-on and reset command: rise filter all ones, fall all zero.
// RQ17: Condition bits track live, unlatched, read-only.
// RQ18: Filters read-write, kept across clear-status and queries.
// RQ19: Event query returns value and clears it; new events kept.
`timescale 1ns/10ps
`default_nettype none
`include "sesg_regs.svh"

module sesg_top (
   input wire logic mclk,
   input wire logic rst,
   input wire sesg_pkg::sesg_word_t cond_in,
   input wire sesg_pkg::sesg_word_t direct_evt,
   input wire logic reset_cmd,
   input wire logic clr_status,
   input wire logic qry_valid,
   input wire sesg_pkg::sesg_sel_t qry_sel,
   input wire logic wr_valid,
   input wire sesg_pkg::sesg_sel_t wr_sel,
   input wire sesg_pkg::sesg_word_t wr_data,
   input wire logic que_push,
   input wire sesg_pkg::sesg_word_t que_push_data,
   output logic que_full,
   output logic rsp_valid_ff,
   output sesg_pkg::sesg_word_t rsp_data,
   output sesg_pkg::sesg_word_t summary_word_ff
);

   sesg_pkg::sesg_word_t cond_prev_ff;
   sesg_pkg::sesg_word_t rise_mask_ff;
   sesg_pkg::sesg_word_t fall_mask_ff;
   sesg_pkg::sesg_word_t evt_ff;
   sesg_pkg::sesg_word_t ena_ff;
   sesg_pkg::sesg_word_t rsp_reg_ff;
   sesg_pkg::sesg_word_t nxt_evt;
   sesg_pkg::sesg_word_t nxt_rsp;
   sesg_pkg::sesg_word_t pass_w;
   sesg_pkg::sesg_word_t cond_live;
   sesg_pkg::sesg_word_t que_rd_data;
   logic rsp_que_ff;
   logic evt_query;
   logic que_pop;
   logic que_empty;
   logic evt_summary;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Condition and transition filters
   // ----------------------------------------
   // Direct positions have no condition behind them
   assign cond_live = cond_in & `SESG_USED_MASK
      & ~`SESG_DIRECT_MASK; // [RQ17]

   // Previous level resets low, so a high condition at release counts
   // as a rising transition
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cond_prev_ff <= '0;
      end else begin
         cond_prev_ff <= cond_live;
      end
   end

   always_comb begin
      pass_w = ((cond_live & ~cond_prev_ff & rise_mask_ff)
         | (~cond_live & cond_prev_ff & fall_mask_ff))
         & ~`SESG_DIRECT_MASK; // [RQ1] [RQ15]
      pass_w = pass_w | (direct_evt & `SESG_DIRECT_MASK); // [RQ5]
      pass_w = pass_w & `SESG_USED_MASK;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rise_mask_ff <= `SESG_RISE_RST; // [RQ16]
         fall_mask_ff <= `SESG_FALL_RST;
      end else if (reset_cmd) begin
         rise_mask_ff <= `SESG_RISE_RST; // [RQ16]
         fall_mask_ff <= `SESG_FALL_RST;
      end else if (wr_valid) begin
         // Clear-status and queries leave the filters alone
         if (wr_sel == sesg_pkg::SEL_RISE) begin
            rise_mask_ff <= wr_data; // [RQ18]
         end
         if (wr_sel == sesg_pkg::SEL_FALL) begin
            fall_mask_ff <= wr_data; // [RQ18]
         end
      end
   end

   // ----------------------------------------
   // Latched events
   // ----------------------------------------
   assign evt_query = qry_valid && (qry_sel == sesg_pkg::SEL_EVENT);

   always_comb begin
      // Set wins: a transition in the clearing cycle is kept
      if (evt_query || clr_status) begin
         nxt_evt = pass_w; // [RQ2] [RQ19]
      end else begin
         nxt_evt = evt_ff | pass_w; // [RQ2] [RQ3]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         evt_ff <= '0;
      end else begin
         evt_ff <= nxt_evt & `SESG_USED_MASK; // [RQ4]
      end
   end

   // ----------------------------------------
   // Enable mask and summaries
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ena_ff <= `SESG_ENA_RST;
      end else if (wr_valid && wr_sel == sesg_pkg::SEL_ENABLE) begin
         ena_ff <= wr_data & `SESG_USED_MASK; // [RQ7] [RQ8]
      end
   end

   assign evt_summary = |(evt_ff & ena_ff); // [RQ6]

   // Summaries only leave as bits of the higher-level word
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         summary_word_ff <= '0;
      end else begin
         summary_word_ff <= '0;
         summary_word_ff[`SESG_SUM_EVT_BIT] <= evt_summary; // [RQ9]
         summary_word_ff[`SESG_SUM_QUE_BIT] <= !que_empty; // [RQ11]
      end
   end

   // ----------------------------------------
   // Status queue
   // ----------------------------------------
   // This is a status queue; the output queue lives elsewhere and
   // never sees clear-status
   assign que_pop = qry_valid && (qry_sel == sesg_pkg::SEL_QUEUE);

   sesg_queue u_queue (
      .mclk(mclk),
      .rst(rst),
      .push(que_push),
      .push_data(que_push_data),
      .pop(que_pop), // [RQ12]
      .clr(clr_status), // [RQ13]
      .rd_data_ff(que_rd_data),
      .empty(que_empty),
      .full(que_full)
   );

   // ----------------------------------------
   // Query answers
   // ----------------------------------------
   always_comb begin
      case (qry_sel)
         sesg_pkg::SEL_COND: nxt_rsp = cond_live; // [RQ17]
         sesg_pkg::SEL_EVENT: nxt_rsp = evt_ff; // [RQ19]
         sesg_pkg::SEL_ENABLE: nxt_rsp = ena_ff; // [RQ7]
         sesg_pkg::SEL_RISE: nxt_rsp = rise_mask_ff; // [RQ18]
         sesg_pkg::SEL_FALL: nxt_rsp = fall_mask_ff;
         default: nxt_rsp = '0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rsp_valid_ff <= 1'b0;
         rsp_reg_ff <= '0;
         rsp_que_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= qry_valid;
         rsp_que_ff <= que_pop;
         if (qry_valid) begin
            rsp_reg_ff <= nxt_rsp;
         end
      end
   end

   // Both sources are flip-flops; queue data is already registered
   assign rsp_data = rsp_que_ff ? que_rd_data : rsp_reg_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_pass;
      |pass_w;
   endsequence

   sequence s_no_clear;
      !evt_query && !clr_status;
   endsequence

   sequence s_ena_wr;
      wr_valid && (wr_sel == sesg_pkg::SEL_ENABLE);
   endsequence

   sequence s_rise_seen;
      |(cond_live & ~cond_prev_ff & rise_mask_ff);
   endsequence

   sequence s_fall_seen;
      |(~cond_live & cond_prev_ff & fall_mask_ff);
   endsequence

   AST_PASS_SETS: assert property (s_pass |=> // [RQ1]
      ((evt_ff & $past(pass_w)) == $past(pass_w)))
      else $error("Passed transition not latched");

   AST_EVT_HOLD: assert property (s_no_clear |=> // [RQ2]
      ((evt_ff & $past(evt_ff)) == $past(evt_ff)))
      else $error("Event bit lost without clear");

   AST_CLR_STATUS: assert property (clr_status |=> // [RQ2]
      (evt_ff == $past(pass_w)))
      else $error("Clear-status left stale events");

   AST_NO_EXTRA: assert property (s_no_clear |=> // [RQ3]
      (evt_ff == ($past(evt_ff) | $past(pass_w))))
      else $error("Event set without passed transition");

   AST_UNUSED_ZERO: assert property ( // [RQ4]
      ((evt_ff | ena_ff) & ~`SESG_USED_MASK) == '0)
      else $error("Unused bit set");

   AST_DIRECT_SET: assert property ( // [RQ5]
      (|(direct_evt & `SESG_DIRECT_MASK)) |=>
      ((evt_ff & $past(direct_evt) & `SESG_DIRECT_MASK) ==
      ($past(direct_evt) & `SESG_DIRECT_MASK)))
      else $error("Direct event not latched");

   AST_SUMMARY: assert property ( // [RQ6]
      summary_word_ff[`SESG_SUM_EVT_BIT] == $past(evt_summary))
      else $error("Summary bit wrong");

   AST_ENA_WRITE: assert property (s_ena_wr |=> // [RQ7]
      (ena_ff == ($past(wr_data) & `SESG_USED_MASK)))
      else $error("Enable write not applied");

   AST_ENA_READ: assert property ( // [RQ7]
      (qry_valid && qry_sel == sesg_pkg::SEL_ENABLE) |=>
      (rsp_data == $past(ena_ff)))
      else $error("Enable query answered wrong");

   AST_ENA_KEEP: assert property ( // [RQ8]
      (!wr_valid || wr_sel != sesg_pkg::SEL_ENABLE) |=>
      $stable(ena_ff))
      else $error("Enable changed without write");

   AST_SUM_SPARE: assert property ( // [RQ9]
      (summary_word_ff & ~(16'h0001 << `SESG_SUM_EVT_BIT)
      & ~(16'h0001 << `SESG_SUM_QUE_BIT)) == '0)
      else $error("Spare summary bit set");

   AST_QUE_SUM: assert property ( // [RQ11]
      summary_word_ff[`SESG_SUM_QUE_BIT] == !$past(que_empty))
      else $error("Queue summary wrong");

   AST_EMPTY_READ: assert property ( // [RQ12]
      (qry_valid && qry_sel == sesg_pkg::SEL_QUEUE && que_empty) |=>
      (rsp_data == '0))
      else $error("Empty queue read not zero");

   AST_RISE_LATCH: assert property (s_rise_seen |=> // [RQ15]
      ((evt_ff & $past(cond_live & ~cond_prev_ff & rise_mask_ff))
      == $past(cond_live & ~cond_prev_ff & rise_mask_ff)))
      else $error("Rising transition not latched");

   AST_FALL_LATCH: assert property (s_fall_seen |=> // [RQ15]
      ((evt_ff & $past(~cond_live & cond_prev_ff & fall_mask_ff))
      == $past(~cond_live & cond_prev_ff & fall_mask_ff)))
      else $error("Falling transition not latched");

   AST_RST_CMD: assert property (reset_cmd |=> // [RQ16]
      (rise_mask_ff == `SESG_RISE_RST && fall_mask_ff == '0))
      else $error("Filters not preset by reset command");

   AST_COND_READ: assert property ( // [RQ17]
      (qry_valid && qry_sel == sesg_pkg::SEL_COND) |=>
      (rsp_valid_ff && rsp_data == $past(cond_live)))
      else $error("Condition query answered wrong");

   AST_FILT_KEEP: assert property ((!wr_valid && !reset_cmd) |=> // [RQ18]
      ($stable(rise_mask_ff) && $stable(fall_mask_ff)))
      else $error("Filter changed without write");

   AST_RISE_WRITE: assert property ( // [RQ18]
      (wr_valid && !reset_cmd && wr_sel == sesg_pkg::SEL_RISE) |=>
      (rise_mask_ff == $past(wr_data)))
      else $error("Rise filter write not applied");

   AST_FALL_WRITE: assert property ( // [RQ18]
      (wr_valid && !reset_cmd && wr_sel == sesg_pkg::SEL_FALL) |=>
      (fall_mask_ff == $past(wr_data)))
      else $error("Fall filter write not applied");

   AST_QUERY_CLR: assert property (evt_query |=> // [RQ19]
      (rsp_valid_ff && rsp_data == $past(evt_ff)
      && evt_ff == $past(pass_w)))
      else $error("Event query did not read and clear");

endmodule
`default_nettype wire

// [core/sesg_regs.svh]
// Constants of the status event summary group: field layouts,
// reset values and queue sizing.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SESG_REGS_SVH
`define SESG_REGS_SVH

// ----------------------------------------
// Register widths and field layout
// ----------------------------------------
`define SESG_W 16
// Bit 15 of a group is never used; it reads zero except in the rise and fall filters
`define SESG_USED_MASK 16'h7FFF
// Positions driven only by a direct internal event, no filter pair
`define SESG_DIRECT_MASK 16'h0007

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SESG_RISE_RST 16'hFFFF
`define SESG_FALL_RST 16'h0000
`define SESG_ENA_RST 16'h0000

// ----------------------------------------
// Higher-level summary word bit positions
// ----------------------------------------
`define SESG_SUM_EVT_BIT 0
`define SESG_SUM_QUE_BIT 2

// ----------------------------------------
// Status queue sizing
// ----------------------------------------
`define SESG_QUE_DEPTH 8
`define SESG_QUE_AW 3

`endif

// [core/sesg_pkg.sv]
// Types shared by the status event summary group.
// Assumes sesg_regs.svh sits on the include path.
`default_nettype none
`include "sesg_regs.svh"

package sesg_pkg;

   // ----------------------------------------
   // Register selector of query and write ports
   // ----------------------------------------
   typedef enum logic [2:0] {
      SEL_COND   = 3'h0,
      SEL_EVENT  = 3'h1,
      SEL_ENABLE = 3'h2,
      SEL_RISE   = 3'h3,
      SEL_FALL   = 3'h4,
      SEL_QUEUE  = 3'h5
   } sesg_sel_t;

   typedef logic [`SESG_W-1:0] sesg_word_t;

endpackage
`default_nettype wire

// [core/sesg_queue.sv]
// Status queue: first in, first out, with registered read data.
// Assumes push and pop come from logic on mclk.
`timescale 1ns/10ps
`default_nettype none
`include "sesg_regs.svh"

module sesg_queue (
   input wire logic mclk,
   input wire logic rst,
   input wire logic push,
   input wire sesg_pkg::sesg_word_t push_data,
   input wire logic pop,
   input wire logic clr,
   output sesg_pkg::sesg_word_t rd_data_ff,
   output logic empty,
   output logic full
);

   sesg_pkg::sesg_word_t mem [`SESG_QUE_DEPTH];
   logic [`SESG_QUE_AW-1:0] wptr_ff;
   logic [`SESG_QUE_AW-1:0] rptr_ff;
   logic [`SESG_QUE_AW:0] cnt_ff;
   logic do_push;
   logic do_pop;
   logic [`SESG_QUE_AW-1:0] wr_addr;

   // ----------------------------------------
   // Flags and strobes
   // ----------------------------------------
   assign empty = (cnt_ff == '0);
   assign full = (cnt_ff == (`SESG_QUE_AW+1)'(`SESG_QUE_DEPTH));
   // A push in the clearing cycle survives as the only entry
   assign do_push = push && (clr || !full);
   assign do_pop = pop && !clr && !empty;
   assign wr_addr = clr ? '0 : wptr_ff;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem[wr_addr] <= push_data; // [RQ10]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data_ff <= '0;
      end else if (pop) begin
         // Empty read answers zero
         rd_data_ff <= do_pop ? mem[rptr_ff] : '0; // [RQ10]
      end
   end

   // ----------------------------------------
   // Pointers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
      end else if (clr) begin
         wptr_ff <= do_push ? `SESG_QUE_AW'(1) : '0; // [RQ13]
         rptr_ff <= '0;
         cnt_ff <= do_push ? (`SESG_QUE_AW+1)'(1) : '0;
      end else begin
         if (do_push) begin
            wptr_ff <= wptr_ff + `SESG_QUE_AW'(1);
         end
         if (do_pop) begin
            rptr_ff <= rptr_ff + `SESG_QUE_AW'(1); // [RQ12]
         end
         cnt_ff <= cnt_ff + (`SESG_QUE_AW+1)'(do_push)
            - (`SESG_QUE_AW+1)'(do_pop);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_QUE_CLEAR: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
      (clr && !push) |=> empty)
      else $error("Queue not empty after clear");

   AST_QUE_DRAIN: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
      (cnt_ff == (`SESG_QUE_AW+1)'(1) && pop && !push) |=> empty)
      else $error("Queue not empty after last read");

endmodule
`default_nettype wire

// [tb/sesg_host_model.sv]
// Host controller model: queries, writes and commands for the group.
// Assumes its tasks are called just after a falling edge of mclk.
`timescale 1ns/10ps
`default_nettype none

module sesg_host_model #(
   parameter int POLL_GAP = 2
) (
   input wire logic mclk,
   input wire logic rsp_valid_ff,
   input wire sesg_pkg::sesg_word_t rsp_data,
   output logic qry_valid,
   output sesg_pkg::sesg_sel_t qry_sel,
   output logic wr_valid,
   output sesg_pkg::sesg_sel_t wr_sel,
   output sesg_pkg::sesg_word_t wr_data,
   output logic clr_status,
   output logic reset_cmd
);
   initial begin
      qry_valid = 1'b0;
      qry_sel = sesg_pkg::SEL_COND;
      wr_valid = 1'b0;
      wr_sel = sesg_pkg::SEL_COND;
      wr_data = 16'h0000;
      clr_status = 1'b0;
      reset_cmd = 1'b0;
   end

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   // Idle gap after a poll; scaled down, a real host waits far longer
   task automatic query(input sesg_pkg::sesg_sel_t sel,
                        output sesg_pkg::sesg_word_t d);
      qry_valid = 1'b1;
      qry_sel = sel;
      @(negedge mclk);
      qry_valid = 1'b0;
      d = (rsp_valid_ff === 1'b1) ? rsp_data : 16'hXXXX;
      repeat (POLL_GAP) @(negedge mclk);
   endtask

   task automatic write(input sesg_pkg::sesg_sel_t sel,
                        input sesg_pkg::sesg_word_t d);
      wr_valid = 1'b1;
      wr_sel = sel;
      wr_data = d;
      @(negedge mclk);
      wr_valid = 1'b0;
      // Released data is scrambled so stale values cannot help
      wr_data = ~d;
   endtask

   task automatic clear();
      clr_status = 1'b1;
      @(negedge mclk);
      clr_status = 1'b0;
   endtask

   task automatic reset_pulse();
      reset_cmd = 1'b1;
      @(negedge mclk);
      reset_cmd = 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the status event summary group.
// Assumes the host model file and the design are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb;
   typedef struct {
      sesg_pkg::sesg_sel_t s;
      sesg_pkg::sesg_word_t d;
      sesg_pkg::sesg_word_t e;
   } sesg_row_t;

   logic mclk, rst, reset_cmd, clr_status, qry_valid, wr_valid;
   logic que_push, que_full, rsp_valid_ff;
   sesg_pkg::sesg_sel_t qry_sel, wr_sel;
   sesg_pkg::sesg_word_t cond_in, direct_evt, wr_data, que_push_data;
   sesg_pkg::sesg_word_t rsp_data, summary_word_ff, d;
   int miscompares = 0;
   int tests_run = 0;
   sesg_row_t rows[5] = '{
      '{sesg_pkg::SEL_ENABLE, 16'hFFFF, 16'h7FFF},
      '{sesg_pkg::SEL_RISE, 16'h0F0F, 16'h0F0F},
      '{sesg_pkg::SEL_FALL, 16'h00F0, 16'h00F0},
      '{sesg_pkg::SEL_EVENT, 16'hFFFF, 16'h0000},
      '{sesg_pkg::SEL_COND, 16'hFFFF, 16'h0000}};

   sesg_top DUT (.mclk(mclk), .rst(rst), .cond_in(cond_in),
      .direct_evt(direct_evt), .reset_cmd(reset_cmd),
      .clr_status(clr_status), .qry_valid(qry_valid), .qry_sel(qry_sel),
      .wr_valid(wr_valid), .wr_sel(wr_sel), .wr_data(wr_data),
      .que_push(que_push), .que_push_data(que_push_data),
      .que_full(que_full), .rsp_valid_ff(rsp_valid_ff),
      .rsp_data(rsp_data), .summary_word_ff(summary_word_ff));

   sesg_host_model host (.mclk(mclk), .rsp_valid_ff(rsp_valid_ff),
      .rsp_data(rsp_data), .qry_valid(qry_valid), .qry_sel(qry_sel),
      .wr_valid(wr_valid), .wr_sel(wr_sel), .wr_data(wr_data),
      .clr_status(clr_status), .reset_cmd(reset_cmd));

   // ----------------------------------------
   // Clock, helpers and verdict
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic chk(input sesg_pkg::sesg_word_t g,
                      input sesg_pkg::sesg_word_t e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: word %h, wanted %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: bit %b, wanted %b", $time, g, e);
      end
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Whole run is about a hundred and twenty cycles
   initial begin
      #50000;
      miscompares++;
      give_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      cond_in = 16'h0000;
      direct_evt = 16'h0000;
      que_push = 1'b0;
      que_push_data = 16'h0000;
      idle(5);
      rst = 1'b0;
      host.query(sesg_pkg::SEL_RISE, d);
      chk(d, 16'hFFFF);
      host.query(sesg_pkg::SEL_FALL, d);
      chk(d, 16'h0000);
      chk(summary_word_ff, 16'h0000);
      foreach (rows[i]) begin
         host.write(rows[i].s, rows[i].d);
         host.query(rows[i].s, d);
         chk(d, rows[i].e);
      end
      // Bit 3 passes rising only, bit 4 falling only
      cond_in = 16'h0018;
      idle(2);
      cond_in = 16'h0000;
      idle(2);
      cond_in = 16'h8018;
      idle(3);
      chk(summary_word_ff, 16'h0001);
      host.query(sesg_pkg::SEL_COND, d);
      chk(d, 16'h0018);
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0018);
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0000);
      // Transition in the very cycle of the query survives it
      cond_in = 16'h0000;
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0000);
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0010);
      direct_evt = 16'h0005;
      idle(1);
      direct_evt = 16'h0000;
      idle(2);
      chk(summary_word_ff, 16'h0001);
      host.write(sesg_pkg::SEL_ENABLE, 16'h0010);
      idle(2);
      chk(summary_word_ff, 16'h0000);
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0005);
      direct_evt = 16'h0001;
      idle(1);
      direct_evt = 16'h0000;
      idle(1);
      host.clear();
      idle(1);
      host.query(sesg_pkg::SEL_EVENT, d);
      chk(d, 16'h0000);
      host.query(sesg_pkg::SEL_ENABLE, d);
      chk(d, 16'h0010);
      host.query(sesg_pkg::SEL_RISE, d);
      chk(d, 16'h0F0F);
      // Queue order, summary and draining
      for (int i = 1; i <= 3; i++) begin
         que_push = 1'b1;
         que_push_data = 16'hA000 + 16'(i);
         idle(1);
      end
      que_push = 1'b0;
      idle(2);
      chk(summary_word_ff, 16'h0004);
      for (int i = 1; i <= 3; i++) begin
         host.query(sesg_pkg::SEL_QUEUE, d);
         chk(d, 16'hA000 + 16'(i));
      end
      chk(summary_word_ff, 16'h0000);
      host.query(sesg_pkg::SEL_QUEUE, d);
      chk(d, 16'h0000);
      // Overfill, then clear-status empties it
      for (int i = 0; i < 9; i++) begin
         que_push = 1'b1;
         que_push_data = 16'(i);
         idle(1);
      end
      que_push = 1'b0;
      chk1(que_full, 1'b1);
      host.clear();
      idle(2);
      chk(summary_word_ff, 16'h0000);
      chk1(que_full, 1'b0);
      host.reset_pulse();
      host.query(sesg_pkg::SEL_RISE, d);
      chk(d, 16'hFFFF);
      host.query(sesg_pkg::SEL_FALL, d);
      chk(d, 16'h0000);
      host.query(sesg_pkg::SEL_ENABLE, d);
      chk(d, 16'h0010);
      // Fall filter loaded so the second reset has something to undo
      host.write(sesg_pkg::SEL_FALL, 16'h00F0);
      // Second reset in mid-run
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      host.query(sesg_pkg::SEL_ENABLE, d);
      chk(d, 16'h0000);
      host.query(sesg_pkg::SEL_FALL, d);
      chk(d, 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
